// ---- verilog/alert_reg_pkg.sv ----
// Purpose: Constants for the alert limit register bank
// Assumes: 16-bit registers, byte-wide register index from the serial engine
// Notes:   Temperatures and rates use 1/128 degC units when left-aligned to 16 bits
`default_nettype none
package alert_reg_pkg;
  // ==========================================================================
  // Register index map
  localparam logic [7:0] ADDR_LOWER = 8'h04;
  localparam logic [7:0] ADDR_UPPER = 8'h05;
  localparam logic [7:0] ADDR_BAND = 8'h06;
  localparam logic [7:0] ADDR_SLEW = 8'h07;
  localparam logic [7:0] ADDR_SN_HIGH = 8'h08;
  localparam logic [7:0] ADDR_SN_MID = 8'h09;
  // ==========================================================================
  // Field layout
  localparam int REG_W = 16;
  localparam int LIMIT_W = 14;
  localparam int LIMIT_LSB = 2;
  localparam int BAND_W = 8;
  localparam int UPPER_BAND_LSB = 8;
  localparam int LOWER_BAND_LSB = 0;
  localparam int SLEW_W = 13;
  localparam int SLEW_LSB = 2;
  localparam int SLEW_MSB = 14;
  localparam int SN_W = 48;
  localparam int SN_HIGH_LSB = 32;
  localparam int SN_MID_LSB = 16;
  // One band step of 0.5 degC is 64 counts of 1/128 degC
  localparam int BAND_SHIFT = 6;
  // Compare width keeps limit +/- band free of overflow
  localparam int CMP_W = 18;
  // ==========================================================================
  // Reset values
  localparam logic [15:0] UPPER_RST = 16'h2A80;
  localparam logic [15:0] LOWER_RST = 16'hF380;
  localparam logic [15:0] BAND_RST = 16'h0A0A;
  localparam logic [15:0] SLEW_RST = 16'h0500;
endpackage
`default_nettype wire

// ---- verilog/alert_limit_regs.sv ----
// Purpose: Alert limit, release band, rise-rate ceiling and serial number registers
// Assumes: Register strobes, temperature and rate come from logic on i_clk
// Notes:   Register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Upper limit is 14-bit two's complement in bits 15:2, 0.03125 degC steps
// - Upper-limit encoding spans plus or minus 256 degC
// - Upper limit resets to 85 degC, register value 2A80h
// - Both limits are ignored while upper limit is at or below lower limit
// - Bits 1:0 of upper-limit and ceiling registers always read zero
// - Each release band is unsigned 8-bit, 0.5 degC per step
// - Upper band in bits 15:8, lower band in 7:0, each resets to 5 degC
// - Upper release threshold equals upper limit minus upper band
// - Lower release threshold equals lower limit plus lower band
// - Rise-rate ceiling is unsigned 13-bit in bits 14:2, 0.03125 degC/s steps
// - Rise-rate ceiling resets to 10 degC/s, register value 0500h
// - Rate alert only when positive rate of change exceeds the ceiling
// - Bit 15 of the ceiling register always reads zero
// - Serial number bits 47:32 read from a read-only register, bit 47 on top
// - Serial number bits 31:16 read from the next read-only register
// - Lower limit uses the upper-limit encoding and resets to -25 degC
module alert_limit_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_sample_valid,
  input wire logic signed [15:0] i_temp,
  input wire logic signed [15:0] i_rate,
  input wire logic [47:0] i_serial_number,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_rhit,
  output logic o_upper_alert,
  output logic o_lower_alert,
  output logic o_rate_alert,
  output logic o_limits_active
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [alert_reg_pkg::LIMIT_W-1:0] upper;
    logic [alert_reg_pkg::LIMIT_W-1:0] lower;
    logic [alert_reg_pkg::BAND_W-1:0] upper_band;
    logic [alert_reg_pkg::BAND_W-1:0] lower_band;
    logic [alert_reg_pkg::SLEW_W-1:0] ceiling;
    logic [alert_reg_pkg::REG_W-1:0] rdata;
    logic rvalid;
    logic rhit;
    logic upper_alert;
    logic lower_alert;
    logic rate_alert;
    logic active;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ==========================================================================
  // Thresholds in 1/128 degC, sign-extended so limit +/- band cannot wrap
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic [15:0] ceiling_reg;
  logic signed [17:0] temp_w;
  logic signed [17:0] upper_w;
  logic signed [17:0] lower_w;
  logic signed [17:0] upper_band_w;
  logic signed [17:0] lower_band_w;
  logic signed [17:0] upper_release;
  logic signed [17:0] lower_release;
  logic limits_valid;
  logic rate_over;

  // Reserved bits are built as zero, so every read of them returns zero
  assign upper_reg = {s_q.upper, {alert_reg_pkg::LIMIT_LSB{1'b0}}};
  assign lower_reg = {s_q.lower, {alert_reg_pkg::LIMIT_LSB{1'b0}}};
  assign ceiling_reg = {1'b0, s_q.ceiling, {alert_reg_pkg::SLEW_LSB{1'b0}}};

  // Left-aligned limit has the same 1/128 degC scale as the reading
  assign temp_w = alert_reg_pkg::CMP_W'(i_temp);
  assign upper_w = alert_reg_pkg::CMP_W'(signed'(upper_reg));
  assign lower_w = alert_reg_pkg::CMP_W'(signed'(lower_reg));
  assign upper_band_w = signed'(alert_reg_pkg::CMP_W'(
    {s_q.upper_band, {alert_reg_pkg::BAND_SHIFT{1'b0}}}));
  assign lower_band_w = signed'(alert_reg_pkg::CMP_W'(
    {s_q.lower_band, {alert_reg_pkg::BAND_SHIFT{1'b0}}}));
  assign upper_release = upper_w - upper_band_w;
  assign lower_release = lower_w + lower_band_w;
  assign limits_valid = upper_w > lower_w;
  // Ceiling is never negative, so exceeding it implies a rising temperature
  assign rate_over = (i_rate > signed'(ceiling_reg)) && (i_rate > 16'sh0000);

  // ==========================================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // Writes to read-only or unmapped indices are dropped silently
    if (i_wr_en) begin
      unique case (i_addr)
        alert_reg_pkg::ADDR_LOWER: begin
          s_d.lower = i_wdata[alert_reg_pkg::REG_W-1:alert_reg_pkg::LIMIT_LSB];
        end
        alert_reg_pkg::ADDR_UPPER: begin
          s_d.upper = i_wdata[alert_reg_pkg::REG_W-1:alert_reg_pkg::LIMIT_LSB];
        end
        alert_reg_pkg::ADDR_BAND: begin
          s_d.upper_band = i_wdata[alert_reg_pkg::UPPER_BAND_LSB +: alert_reg_pkg::BAND_W];
          s_d.lower_band = i_wdata[alert_reg_pkg::LOWER_BAND_LSB +: alert_reg_pkg::BAND_W];
        end
        alert_reg_pkg::ADDR_SLEW: begin
          s_d.ceiling = i_wdata[alert_reg_pkg::SLEW_MSB:alert_reg_pkg::SLEW_LSB];
        end
        default: begin
        end
      endcase
    end
    // Read returns the value held before a same-cycle write
    if (i_rd_en) begin
      s_d.rvalid = 1'b1;
      s_d.rhit = 1'b1;
      unique case (i_addr)
        alert_reg_pkg::ADDR_LOWER: s_d.rdata = lower_reg;
        alert_reg_pkg::ADDR_UPPER: s_d.rdata = upper_reg;
        alert_reg_pkg::ADDR_BAND: s_d.rdata = {s_q.upper_band, s_q.lower_band};
        alert_reg_pkg::ADDR_SLEW: s_d.rdata = ceiling_reg;
        alert_reg_pkg::ADDR_SN_HIGH: begin
          s_d.rdata = i_serial_number[alert_reg_pkg::SN_HIGH_LSB +: alert_reg_pkg::REG_W];
        end
        alert_reg_pkg::ADDR_SN_MID: begin
          s_d.rdata = i_serial_number[alert_reg_pkg::SN_MID_LSB +: alert_reg_pkg::REG_W];
        end
        default: begin
          s_d.rdata = '0;
          s_d.rhit = 1'b0;
        end
      endcase
    end
    s_d.active = limits_valid;
    // Bad limit pair clears both alerts at once, not at the next sample
    if (!limits_valid) begin
      s_d.upper_alert = 1'b0;
      s_d.lower_alert = 1'b0;
    end else if (i_sample_valid) begin
      if (temp_w >= upper_w) begin
        s_d.upper_alert = 1'b1;
      end else if (temp_w < upper_release) begin
        s_d.upper_alert = 1'b0;
      end
      if (temp_w <= lower_w) begin
        s_d.lower_alert = 1'b1;
      end else if (temp_w > lower_release) begin
        s_d.lower_alert = 1'b0;
      end
    end
    // Rate alert follows each new rate sample
    if (i_sample_valid) begin
      s_d.rate_alert = rate_over;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q.upper <= alert_reg_pkg::UPPER_RST[alert_reg_pkg::REG_W-1:alert_reg_pkg::LIMIT_LSB];
      s_q.lower <= alert_reg_pkg::LOWER_RST[alert_reg_pkg::REG_W-1:alert_reg_pkg::LIMIT_LSB];
      s_q.upper_band <= alert_reg_pkg::BAND_RST[alert_reg_pkg::UPPER_BAND_LSB +: alert_reg_pkg::BAND_W];
      s_q.lower_band <= alert_reg_pkg::BAND_RST[alert_reg_pkg::LOWER_BAND_LSB +: alert_reg_pkg::BAND_W];
      s_q.ceiling <= alert_reg_pkg::SLEW_RST[alert_reg_pkg::SLEW_MSB:alert_reg_pkg::SLEW_LSB];
      s_q.rdata <= '0;
      s_q.rvalid <= 1'b0;
      s_q.rhit <= 1'b0;
      s_q.upper_alert <= 1'b0;
      s_q.lower_alert <= 1'b0;
      s_q.rate_alert <= 1'b0;
      s_q.active <= 1'b1;
    end else if (i_ce) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_rvalid = s_q.rvalid;
  assign o_rhit = s_q.rhit;
  assign o_upper_alert = s_q.upper_alert;
  assign o_lower_alert = s_q.lower_alert;
  assign o_rate_alert = s_q.rate_alert;
  assign o_limits_active = s_q.active;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_RESET_VALUES: assert property (
    $rose(i_rst_n) |-> (upper_reg == alert_reg_pkg::UPPER_RST)
      && (lower_reg == alert_reg_pkg::LOWER_RST)
      && ({s_q.upper_band, s_q.lower_band} == alert_reg_pkg::BAND_RST)
      && (ceiling_reg == alert_reg_pkg::SLEW_RST))
    else $error("register reset values wrong");

  AST_UPPER_READBACK: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_UPPER) |=>
      o_rvalid && o_rdata[1:0] == 2'h0 && o_rdata == $past(upper_reg))
    else $error("upper limit readback wrong");

  AST_UPPER_WRITE: assert property (
    (i_ce && i_wr_en && i_addr == alert_reg_pkg::ADDR_UPPER) |=>
      upper_reg == {$past(i_wdata[15:2]), 2'h0})
    else $error("upper limit write not held");

  AST_LOWER_WRITE: assert property (
    (i_ce && i_wr_en && i_addr == alert_reg_pkg::ADDR_LOWER) |=>
      lower_reg == {$past(i_wdata[15:2]), 2'h0})
    else $error("lower limit write not held");

  AST_BAND_WRITE: assert property (
    (i_ce && i_wr_en && i_addr == alert_reg_pkg::ADDR_BAND) |=>
      {s_q.upper_band, s_q.lower_band} == $past(i_wdata))
    else $error("release band write not held");

  AST_CEILING_WRITE: assert property (
    (i_ce && i_wr_en && i_addr == alert_reg_pkg::ADDR_SLEW) |=>
      ceiling_reg == ($past(i_wdata) & 16'h7FFC))
    else $error("ceiling write not held");

  AST_CEILING_READBACK: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_SLEW) |=>
      o_rdata[15] == 1'b0 && o_rdata[1:0] == 2'h0)
    else $error("ceiling reserved bits not zero");

  AST_SERIAL_HIGH: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_SN_HIGH) |=>
      o_rdata == $past(i_serial_number[47:32]) && o_rhit)
    else $error("serial high word wrong");

  AST_SERIAL_MID: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_SN_MID) |=>
      o_rdata == $past(i_serial_number[31:16]) && o_rhit)
    else $error("serial middle word wrong");

  AST_LOWER_READBACK: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_LOWER) |=>
      o_rdata[1:0] == 2'h0 && o_rdata == $past(lower_reg))
    else $error("lower limit readback wrong");

  AST_BAND_READBACK: assert property (
    (i_ce && i_rd_en && i_addr == alert_reg_pkg::ADDR_BAND) |=>
      o_rdata == $past({s_q.upper_band, s_q.lower_band}))
    else $error("release band readback wrong");

  AST_UNMAPPED_READ: assert property (
    (i_ce && i_rd_en && (i_addr < alert_reg_pkg::ADDR_LOWER
      || i_addr > alert_reg_pkg::ADDR_SN_MID)) |=> o_rdata == 16'h0000 && !o_rhit)
    else $error("unmapped read not refused");

  AST_RVALID_PULSE: assert property (
    i_ce |=> o_rvalid == $past(i_rd_en))
    else $error("read valid not one pulse per read");

  AST_RDATA_HOLD: assert property (
    !(i_ce && i_rd_en) |=> $stable(o_rdata) && $stable(o_rhit))
    else $error("read data moved without a read");

  // ==========================================================================
  // Alert checks
  AST_LIMITS_IGNORED: assert property (
    (i_ce && signed'(upper_reg) <= signed'(lower_reg)) |=>
      !o_upper_alert && !o_lower_alert && !o_limits_active)
    else $error("alert raised with invalid limit pair");

  AST_LIMITS_ACTIVE: assert property (
    (i_ce && signed'(upper_reg) > signed'(lower_reg)) |=> o_limits_active)
    else $error("valid limit pair not honoured");

  AST_UPPER_SET: assert property (
    (i_ce && i_sample_valid && limits_valid && temp_w >= upper_w) |=> o_upper_alert)
    else $error("upper alert did not set");

  AST_UPPER_HOLD: assert property (
    (i_ce && o_upper_alert && i_sample_valid && limits_valid
      && temp_w >= upper_w - (18'sd1 <<< alert_reg_pkg::BAND_SHIFT)
        * signed'(18'(s_q.upper_band))) |=> o_upper_alert)
    else $error("upper alert dropped inside band");

  AST_UPPER_RELEASE: assert property (
    (i_ce && o_upper_alert && i_sample_valid && limits_valid
      && temp_w < upper_w - (18'sd1 <<< 6) * signed'(18'(s_q.upper_band))) |=> !o_upper_alert)
    else $error("upper alert did not release");

  AST_LOWER_RELEASE: assert property (
    (i_ce && o_lower_alert && i_sample_valid && limits_valid
      && temp_w > lower_w + (18'sd1 <<< 6) * signed'(18'(s_q.lower_band))) |=> !o_lower_alert)
    else $error("lower alert did not release");

  AST_LOWER_SET: assert property (
    (i_ce && i_sample_valid && limits_valid && temp_w <= lower_w) |=> o_lower_alert)
    else $error("lower alert did not set");

  AST_LOWER_HOLD: assert property (
    (i_ce && o_lower_alert && i_sample_valid && limits_valid
      && temp_w <= lower_w + (18'sd1 <<< alert_reg_pkg::BAND_SHIFT)
        * signed'(18'(s_q.lower_band))) |=> o_lower_alert)
    else $error("lower alert dropped inside band");

  AST_ALERTS_HOLD: assert property (
    (i_ce && !i_sample_valid && limits_valid) |=>
      $stable(o_upper_alert) && $stable(o_lower_alert) && $stable(o_rate_alert))
    else $error("alert moved without a sample");

  AST_RATE_QUIET: assert property (
    (i_ce && i_sample_valid && i_rate <= 16'sh0000) |=> !o_rate_alert)
    else $error("rate alert on a falling temperature");

  AST_RATE_ALERT: assert property (
    (i_ce && i_sample_valid) |=>
      o_rate_alert == ($past(i_rate) > 16'sh0000
        && $past(i_rate) > signed'({1'b0, $past(s_q.ceiling), 2'h0})))
    else $error("rate alert wrong");

  AST_FROZEN: assert property (
    !i_ce |=> $stable(s_q))
    else $error("state moved while clock enable low");

  // ==========================================================================
  // Coverage
  COV_UPPER_CYCLE: cover property (
    o_upper_alert ##[1:50] !o_upper_alert);
  COV_LOWER_ALERT: cover property (
    !o_lower_alert ##1 o_lower_alert);
  COV_RATE_ALERT: cover property (
    $rose(o_rate_alert));
  COV_BAD_PAIR: cover property (
    $fell(o_limits_active));
  COV_UNMAPPED_READ: cover property (
    o_rvalid && !o_rhit);

endmodule
`default_nettype wire

// ---- verification/host_model.sv ----
// Purpose: Serial-bus host stand-in issuing register reads and writes
// Assumes: Strobes change 1 ns after a rising edge and are held one edge
// Notes:   Read data is taken just after the edge that takes the read
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_rhit,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata
);
  // ==========================================================================
  // Bus cycles
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1 o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(posedge i_clk);
    #1 o_wr_en = 1'b0;
    // Stale data would hide a missed strobe
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v,
                    output logic h);
    @(posedge i_clk);
    #1 o_addr = a;
    o_rd_en = 1'b1;
    @(posedge i_clk);
    #1 o_rd_en = 1'b0;
    d = i_rdata;
    v = i_rvalid;
    h = i_rhit;
  endtask
endmodule
`default_nettype wire

// ---- verification/temp_limit_alert_registers_tb.sv ----
// Purpose: Self-checking bench for the alert limit register bank
// Assumes: Host model drives the register port, bench drives samples
// Notes:   Random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module temp_limit_alert_registers_tb;
  logic i_clk, i_rst_n, i_ce, wr, rd, smp_v, rv, rh, rvalid, rhit;
  logic ua, la, ra, act;
  logic [7:0] addr, idx;
  logic [15:0] wdata, rdata, d;
  logic [15:0] exp_q [8'h04:8'h07];
  logic signed [15:0] temp, rate;
  logic [47:0] sn;
  logic [31:0] seed;
  int num_errors, cmp_count;
  // ==========================================================================
  // Clock, design and host
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  alert_limit_regs alert_limit_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .i_sample_valid(smp_v),
    .i_temp(temp), .i_rate(rate), .i_serial_number(sn), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_rhit(rhit), .o_upper_alert(ua), .o_lower_alert(la),
    .o_rate_alert(ra), .o_limits_active(act));
  host_model host_model_i (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .i_rhit(rhit), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr), .o_wdata(wdata));
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Readable image of a write: reserved bits read zero
  function automatic logic [15:0] img(input logic [7:0] a, input logic [15:0] v);
    if (a == 8'h07) return v & 16'h7FFC;
    if (a == 8'h06) return v;
    return v & 16'hFFFC;
  endfunction
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input logic h);
    host_model_i.rd(a, d, rv, rh);
    `CHK(rv, 1'b1)
    `CHK(rh, h)
    `CHK(d, e)
  endtask
  task automatic smp(input logic [15:0] t, input logic [15:0] r);
    @(posedge i_clk);
    #1 temp = t;
    rate = r;
    smp_v = 1'b1;
    @(posedge i_clk);
    #1 smp_v = 1'b0;
  endtask
  task automatic results();
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    results();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    smp_v = 1'b0;
    temp = 16'h0000;
    rate = 16'h0000;
    seed = 32'h40b962f5;
    sn = {seed, seed[15:0] ^ 16'h5A3C};
    num_errors = 0;
    cmp_count = 0;
    exp_q[8'h04] = 16'hF380;
    exp_q[8'h05] = 16'h2A80;
    exp_q[8'h06] = 16'h0A0A;
    exp_q[8'h07] = 16'h0500;
    repeat (3) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    for (int a = 4; a < 8; a++) chk_rd(8'(a), exp_q[8'(a)], 1'b1);
    chk_rd(8'h08, sn[47:32], 1'b1);
    chk_rd(8'h09, sn[31:16], 1'b1);
    chk_rd(8'h0A, 16'h0000, 1'b0);
    host_model_i.wr(8'h08, 16'hFFFF);
    chk_rd(8'h08, sn[47:32], 1'b1);
    host_model_i.wr(8'h05, 16'h8003);
    chk_rd(8'h05, 16'h8000, 1'b1);
    host_model_i.wr(8'h05, 16'h7FFF);
    chk_rd(8'h05, 16'h7FFC, 1'b1);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      idx = 8'h05 + 8'(seed[17:16] % 3);
      exp_q[idx] = img(idx, seed[15:0]);
      host_model_i.wr(idx, seed[15:0]);
      chk_rd(idx, exp_q[idx], 1'b1);
    end
    // Frozen clock enable must drop the write
    @(posedge i_clk);
    #1 i_ce = 1'b0;
    host_model_i.wr(8'h06, 16'h1234);
    i_ce = 1'b1;
    chk_rd(8'h06, exp_q[8'h06], 1'b1);
    host_model_i.wr(8'h05, 16'h2A80);
    host_model_i.wr(8'h06, 16'h0A0A);
    host_model_i.wr(8'h07, 16'h0500);
    smp(16'h2A80, 16'h0500);
    `CHK(ua, 1'b1)
    `CHK(ra, 1'b0)
    smp(16'h2800, 16'h0501);
    `CHK(ua, 1'b1)
    `CHK(ra, 1'b1)
    smp(16'h27FF, 16'h8000);
    `CHK(ua, 1'b0)
    `CHK(ra, 1'b0)
    smp(16'hF380, 16'h0000);
    `CHK(la, 1'b1)
    smp(16'hF600, 16'h0000);
    `CHK(la, 1'b1)
    smp(16'hF601, 16'h0000);
    `CHK(la, 1'b0)
    smp(16'h2A80, 16'h0000);
    host_model_i.wr(8'h04, 16'h2A80);
    @(posedge i_clk);
    #1 `CHK(act, 1'b0)
    `CHK(ua, 1'b0)
    smp(16'h7000, 16'h0000);
    `CHK(ua, 1'b0)
    host_model_i.wr(8'h04, 16'hF380);
    @(posedge i_clk);
    #1 `CHK(act, 1'b1)
    smp(16'h0000, 16'h7FFC);
    `CHK(ra, 1'b1)
    host_model_i.wr(8'h06, 16'h1F1F);
    // Mid-run reset must drop written limits and alerts
    @(posedge i_clk);
    #1 i_rst_n = 1'b0;
    @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    `CHK(ra, 1'b0)
    `CHK(rvalid, 1'b0)
    exp_q[8'h05] = 16'h2A80;
    exp_q[8'h06] = 16'h0A0A;
    exp_q[8'h07] = 16'h0500;
    for (int a = 4; a < 8; a++) chk_rd(8'(a), exp_q[8'(a)], 1'b1);
    results();
  end
endmodule
`default_nettype wire
